// [common/acc_pkg.sv]
// constants and carrier types for the aux and current converter control block
// assumes one 250 MHz clock and synchronous active-high reset in every user
//
// Notes on behaviour
// - start command captures mode, selections, settle option, cell count, pin configs.
// - setting changes wait for a fresh start command to take effect.
// - single run mode performs one round-robin cycle then stops itself.
// - continuous mode cycles until stop code plus start command.
// - eight-cycle mode runs eight round-robin cycles then stops.
// - running flag shows whether a run is in progress; it stays set while waiting for alignment and while frozen in sleep.
// - misc ready flag sets once all misc inputs converted since start.
// - balance ready flag sets once every selected balance channel converted.
// - pin ready flag sets after all pin slots visited; inactive results dropped.
// - aux converter runs only in active mode; sleep freezes, keeps state.
// - wake without reset resumes aux converter from retained state.
// - alignment enabled moves balance slot 5 to match main slot of cell.
// - alignment disabled fixes balance slot to main slot 12 (cell 8).
// - two-bit decimation pick sets current conversion length.
// - current converter starts and stops with the main converter bits.
// - current result is 24-bit two's complement in high, mid, low bytes.
// - after settle, first conversion full period, later ones one third.
// - ready pin option drives first pin low per conversion, high on high read.
// - one pin input per round-robin cycle, eight cycles for all pins.
// - balance result holds default unless locked to one active channel, after settle.
// - channels above highest active channel are skipped.
// - non-converter pins keep their slot but are ignored.
package acc_pkg;

  // ==========================================
  // run modes and slot layout
  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_SINGLE = 2'h1;
  localparam logic [1:0] RUN_CONT = 2'h2;
  localparam logic [1:0] RUN_EIGHT = 2'h3;
  localparam logic [3:0] SLOT_DIE = 4'h0;
  localparam logic [3:0] SLOT_BAL = 4'h5;
  localparam logic [3:0] SLOT_PIN = 4'h6;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [3:0] MAIN_SLOT_CELL8 = 4'hC;
  localparam logic [3:0] MAIN_SLOT_CELL1 = 4'h4;
  localparam logic [2:0] PIN_LAST = 3'h7;
  localparam logic [4:0] SEL_ALL = 5'h00;
  localparam logic [4:0] SEL_CURRENT = 5'h01;
  localparam logic [15:0] BAL_DEFAULT = 16'h8000;
  localparam logic [2:0] CYCLES_EIGHT = 3'h7;

  // ==========================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int SLOT_NS = 8;
  localparam logic [7:0] SLOT_CYC = 8'((SLOT_NS * CLK_MHZ + 999) / 1000);
  localparam int SETTLE0_US = 4300;
  localparam int SETTLE1_US = 2300;
  localparam int SETTLE2_US = 1300;
  localparam int CS_SETTLE_NS = 1000;
  localparam logic [23:0] CS_SETTLE_CYC = 24'((CS_SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam int CS_CONV_BASE_CYC = 768;

  // ==========================================
  // carriers
  typedef struct packed {
    logic [1:0] run_sel;
    logic [4:0] bal_pick;
    logic [1:0] settle_pick;
    logic [3:0] pin_pick;
    logic [3:0] highest_active_channel;
    logic [7:0] pin_is_input;
  } acc_aux_cfg_t;

  typedef struct packed {
    logic misc_results_ready;
    logic balance_results_ready;
    logic pin_results_ready;
    logic running;
  } acc_aux_stat_t;

endpackage : acc_pkg

// [hdl/acc_current.sv]
// current converter sequencer: settle, full first conversion, then thirds
// assumes start/stop come from the main converter control bits
module acc_current (
  input wire logic clk,
  input wire logic srst,
  input wire logic main_go,
  input wire logic main_stop,
  input wire logic [1:0] current_decimation_pick,
  input wire logic [23:0] conv_sample,
  input wire logic high_byte_read,
  input wire logic cs_ready_pin_en,
  output logic [7:0] current_result_high,
  output logic [7:0] current_result_mid,
  output logic [7:0] current_result_low,
  output logic conv_done,
  output logic cs_running,
  output logic ready_pin_low
);
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_SETTLE = 2'b01,
    CS_FIRST = 2'b10,
    CS_NEXT = 2'b11
  } acc_cs_state_t;

  typedef struct packed {
    acc_cs_state_t st;
    logic [23:0] cnt;
    logic [23:0] res;
    logic done;
    logic pin_low;
  } acc_cs_t;

  acc_cs_t s_q, s_d;
  logic [23:0] full_cyc;
  logic [23:0] third_cyc;

  // smaller pick, shorter conversion
  assign full_cyc = 24'(acc_pkg::CS_CONV_BASE_CYC << current_decimation_pick);
  assign third_cyc = 24'(full_cyc / 24'd3);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      CS_IDLE: begin
        if (main_go) begin
          s_d.st = CS_SETTLE;
          s_d.cnt = acc_pkg::CS_SETTLE_CYC;
        end
      end
      CS_SETTLE: begin
        if (s_q.cnt <= 24'd1) begin
          s_d.st = CS_FIRST;
          s_d.cnt = full_cyc;
        end else begin
          s_d.cnt = s_q.cnt - 24'd1;
        end
      end
      CS_FIRST, CS_NEXT: begin
        if (s_q.cnt <= 24'd1) begin
          s_d.st = CS_NEXT;
          s_d.cnt = third_cyc;
          s_d.res = conv_sample;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 24'd1;
        end
      end
      default: s_d.st = CS_IDLE;
    endcase
    if (main_stop) begin
      s_d.st = CS_IDLE;
    end
    // release on high read, but a fresh result in the same cycle wins
    if (high_byte_read) begin
      s_d.pin_low = 1'b0;
    end
    if (s_d.done && cs_ready_pin_en) begin
      s_d.pin_low = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign current_result_high = s_q.res[23:16];
  assign current_result_mid = s_q.res[15:8];
  assign current_result_low = s_q.res[7:0];
  assign conv_done = s_q.done;
  assign cs_running = (s_q.st != CS_IDLE);
  assign ready_pin_low = s_q.pin_low;
endmodule : acc_current

// [hdl/acc_aux_control.sv]
// aux converter round-robin sequencer with the current converter beside it
// assumes inputs synchronous to clk; slot strobe slot_strobe goes to the analog side
module acc_aux_control (
  input wire logic clk,
  input wire logic srst,
  input wire logic aux_go,
  input wire acc_pkg::acc_aux_cfg_t aux_cfg,
  input wire logic sleep_mode,
  input wire logic align_disable,
  input wire logic [3:0] main_cell_target,
  input wire logic [3:0] main_slot,
  input wire logic main_slot_strobe,
  input wire logic [15:0] bal_sample,
  input wire logic main_go,
  input wire logic main_stop,
  input wire logic [1:0] current_decimation_pick,
  input wire logic [23:0] current_sample,
  input wire logic high_byte_read,
  input wire logic cs_ready_pin_en,
  output acc_pkg::acc_aux_stat_t aux_stat,
  output logic [3:0] aux_slot,
  output logic slot_strobe,
  output logic [4:0] bal_channel_now,
  output logic [2:0] pin_now,
  output logic pin_result_keep,
  output logic [15:0] balance_result,
  output logic [7:0] current_result_high,
  output logic [7:0] current_result_mid,
  output logic [7:0] current_result_low,
  output logic current_done,
  output logic current_running,
  output logic first_pin_input_low
);
  // ==========================================
  // state
  typedef enum logic [1:0] {
    AX_IDLE = 2'b00,
    AX_WAIT_ALIGN = 2'b01,
    AX_RUN = 2'b10
  } acc_ax_state_t;

  typedef struct packed {
    acc_ax_state_t st;
    acc_pkg::acc_aux_cfg_t cfg;
    logic [3:0] slot;
    logic [7:0] tick;
    logic [2:0] cycles;
    logic [2:0] pin;
    logic [4:0] bal;
    logic [23:0] settle;
    logic [15:0] bal_res;
    logic [16:0] bal_seen;
    logic misc_rdy;
    logic bal_rdy;
    logic pin_rdy;
    logic strobe;
    logic keep;
  } acc_ax_t;

  acc_ax_t s_q, s_d;
  logic [23:0] settle_cyc;
  logic [3:0] align_slot;
  logic bal_locked;
  logic bal_lock_valid;
  logic [16:0] bal_need;
  logic cycle_end;
  logic [4:0] bal_next;

  // ==========================================
  // derived terms
  // a start must use the settle option it captures, not the one held from before
  always_comb begin
    case (aux_go ? aux_cfg.settle_pick : s_q.cfg.settle_pick)
      2'h1: settle_cyc = 24'(acc_pkg::SETTLE1_US * acc_pkg::CLK_MHZ);
      2'h2: settle_cyc = 24'(acc_pkg::SETTLE2_US * acc_pkg::CLK_MHZ);
      default: settle_cyc = 24'(acc_pkg::SETTLE0_US * acc_pkg::CLK_MHZ);
    endcase
  end

  // slot 5 must meet the main slot of the wanted cell
  assign align_slot = align_disable ? acc_pkg::MAIN_SLOT_CELL8
                    : 4'(acc_pkg::MAIN_SLOT_CELL1 + main_cell_target);

  assign bal_locked = (s_q.cfg.bal_pick != acc_pkg::SEL_ALL);
  // pick n locks to channel n-1; 1 is the current channel
  assign bal_lock_valid = bal_locked && (s_q.cfg.bal_pick == acc_pkg::SEL_CURRENT
                          || (s_q.cfg.bal_pick - 5'd1) <= {1'b0, s_q.cfg.highest_active_channel});

  // bit 0 stands for current channel, bits 1..16 for balance channels
  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : g_need
      if (gi == 0) begin : g_cur
        assign bal_need[gi] = (s_q.cfg.bal_pick == acc_pkg::SEL_ALL) || (s_q.cfg.bal_pick == acc_pkg::SEL_CURRENT);
      end else begin : g_cell
        assign bal_need[gi] = (gi <= 32'(s_q.cfg.highest_active_channel))
                              && (!bal_locked || 32'(s_q.cfg.bal_pick) == gi + 1);
      end
    end
  endgenerate

  // next wanted balance channel, wrapping, skipping inactive ones
  always_comb begin
    logic [4:0] c;
    c = s_q.bal;
    bal_next = s_q.bal;
    for (int k = 0; k < 17; k++) begin
      c = (c >= 5'd16) ? 5'd0 : 5'(c + 5'd1);
      if (bal_need[c] && bal_next == s_q.bal) begin
        bal_next = c;
      end
    end
  end

  assign cycle_end = (s_q.slot == acc_pkg::SLOT_LAST) && (s_q.tick == 8'd0);

  // ==========================================
  // sequencer
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    s_d.keep = 1'b0;
    if (aux_go) begin
      s_d.cfg = aux_cfg;
      s_d.misc_rdy = 1'b0;
      s_d.bal_rdy = 1'b0;
      s_d.pin_rdy = 1'b0;
      s_d.bal_seen = '0;
      s_d.slot = acc_pkg::SLOT_DIE;
      s_d.tick = acc_pkg::SLOT_CYC;
      s_d.cycles = 3'h0;
      s_d.pin = 3'h0;
      // a locked pick never advances, so it must start on its own channel
      s_d.bal = (aux_cfg.bal_pick > acc_pkg::SEL_CURRENT && aux_cfg.bal_pick <= 5'd17)
                ? 5'(aux_cfg.bal_pick - 5'd1) : 5'd0;
      s_d.settle = settle_cyc;
      s_d.bal_res = acc_pkg::BAL_DEFAULT;
      s_d.st = (aux_cfg.run_sel == acc_pkg::RUN_STOP) ? AX_IDLE : AX_WAIT_ALIGN;
    end else if (sleep_mode) begin
      s_d = s_q; // frozen, state kept for wake
      s_d.strobe = 1'b0;
      s_d.keep = 1'b0;
    end else begin
      case (s_q.st)
        AX_IDLE: begin
        end
        AX_WAIT_ALIGN: begin
          // die temperature slot starts so that slot 5 lands on the main target
          if (main_slot_strobe && main_slot == 4'(align_slot - acc_pkg::SLOT_BAL)) begin
            s_d.st = AX_RUN;
            s_d.strobe = 1'b1;
          end
        end
        AX_RUN: begin
          if (s_q.settle != 24'd0) begin
            s_d.settle = s_q.settle - 24'd1;
          end
          if (s_q.tick != 8'd0) begin
            s_d.tick = s_q.tick - 8'd1;
          end else begin
            s_d.tick = acc_pkg::SLOT_CYC;
            s_d.slot = 4'(s_q.slot + 4'd1);
            s_d.strobe = 1'b1;
            if (s_q.slot == acc_pkg::SLOT_BAL && s_q.settle == 24'd0) begin
              s_d.bal_seen[s_q.bal] = 1'b1;
              if (bal_lock_valid) begin
                s_d.bal_res = bal_sample;
              end
              if (!bal_locked) begin
                s_d.bal = bal_next;
                s_d.settle = settle_cyc;
              end
            end
            if (s_q.slot == acc_pkg::SLOT_PIN) begin
              s_d.keep = s_q.cfg.pin_is_input[s_q.pin];
            end
          end
          if (cycle_end) begin
            s_d.misc_rdy = 1'b1;
            s_d.pin = 3'(s_q.pin + 3'd1);
            s_d.cycles = 3'(s_q.cycles + 3'd1);
            if (s_q.pin == acc_pkg::PIN_LAST) begin
              s_d.pin_rdy = 1'b1;
            end
            if (s_q.cfg.run_sel == acc_pkg::RUN_SINGLE) begin
              s_d.st = AX_IDLE;
            end
            if (s_q.cfg.run_sel == acc_pkg::RUN_EIGHT && s_q.cycles == acc_pkg::CYCLES_EIGHT) begin
              s_d.st = AX_IDLE;
            end
          end
        end
        default: s_d.st = AX_IDLE;
      endcase
      if ((s_d.bal_seen & bal_need) == bal_need && bal_need != '0) begin
        s_d.bal_rdy = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.bal_res <= acc_pkg::BAL_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign aux_stat.running = (s_q.st != AX_IDLE);
  assign aux_stat.misc_results_ready = s_q.misc_rdy;
  assign aux_stat.balance_results_ready = s_q.bal_rdy;
  assign aux_stat.pin_results_ready = s_q.pin_rdy;
  assign aux_slot = s_q.slot;
  assign slot_strobe = s_q.strobe;
  assign bal_channel_now = s_q.bal;
  assign pin_now = s_q.pin;
  assign pin_result_keep = s_q.keep;
  assign balance_result = s_q.bal_res;

  acc_current u_current (
    .clk(clk),
    .srst(srst),
    .main_go(main_go),
    .main_stop(main_stop),
    .current_decimation_pick(current_decimation_pick),
    .conv_sample(current_sample),
    .high_byte_read(high_byte_read),
    .cs_ready_pin_en(cs_ready_pin_en),
    .current_result_high(current_result_high),
    .current_result_mid(current_result_mid),
    .current_result_low(current_result_low),
    .conv_done(current_done),
    .cs_running(current_running),
    .ready_pin_low(first_pin_input_low)
  );
endmodule : acc_aux_control

// [test/acc_chk.sv]
// concurrent checks on the ports of acc_aux_control
// assumes one clock and synchronous active-high srst
module acc_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic aux_go,
  input wire acc_pkg::acc_aux_cfg_t aux_cfg,
  input wire logic sleep_mode,
  input wire logic main_stop,
  input wire logic high_byte_read,
  input wire acc_pkg::acc_aux_stat_t aux_stat,
  input wire logic [3:0] aux_slot,
  input wire logic current_done,
  input wire logic current_running,
  input wire logic first_pin_input_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // checks
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_run_start: assert property (aux_go && aux_cfg.run_sel != acc_pkg::RUN_STOP |=> aux_stat.running)
    else $error("running flag not set after start");
  chk_stop_code: assert property (aux_go && aux_cfg.run_sel == acc_pkg::RUN_STOP |=> !aux_stat.running)
    else $error("stop code did not stop the sequencer");
  chk_flags_clear: assert property (aux_go |=> !aux_stat.misc_results_ready && !aux_stat.balance_results_ready
    && !aux_stat.pin_results_ready)
    else $error("ready flags not cleared by start");
  chk_sleep_hold: assert property (sleep_mode && !aux_go |=> $stable(aux_slot) && $stable(aux_stat))
    else $error("sequencer moved while asleep");
  // the srst term covers a reset only one edge long
  chk_ready_hold: assert property ($fell(aux_stat.misc_results_ready) |-> $past(aux_go) || $past(srst))
    else $error("misc ready dropped without start");
  chk_run_end: assert property ($fell(aux_stat.running) |-> $past(aux_go) || $past(srst)
    || aux_stat.misc_results_ready)
    else $error("running dropped with no cause");
  chk_cs_stop: assert property (main_stop |=> !current_running)
    else $error("current converter kept running after stop");
  chk_cs_done: assert property (current_done |-> $past(current_running))
    else $error("conversion done while stopped");
  chk_pin_set: assert property ($rose(first_pin_input_low) |-> current_done)
    else $error("ready pin low without a conversion");
  chk_pin_free: assert property (high_byte_read |=> !first_pin_input_low || current_done)
    else $error("ready pin not released on high byte read");
endmodule : acc_chk

bind acc_aux_control acc_chk acc_chk_inst (.clk, .srst, .aux_go, .aux_cfg, .sleep_mode, .main_stop, .high_byte_read,
  .aux_stat, .aux_slot, .current_done, .current_running, .first_pin_input_low);

// [test/test_aux_and_current_adc_control.sv]
// self-checking bench for acc_aux_control
// assumes the checker is bound in; main converter slots come from a local generator
module test_aux_and_current_adc_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic aux_go = 1'h0;
  acc_pkg::acc_aux_cfg_t aux_cfg = '0;
  logic sleep_mode = 1'h0;
  logic align_disable = 1'h1;
  logic [3:0] main_cell_target = 4'h3;
  logic [3:0] main_slot = 4'h0;
  logic main_slot_strobe = 1'h0;
  logic [15:0] bal_sample = 16'h1234;
  logic main_go = 1'h0;
  logic main_stop = 1'h0;
  logic [1:0] current_decimation_pick = 2'h0;
  logic [23:0] current_sample = 24'hA55AC3;
  logic high_byte_read = 1'h0;
  logic cs_ready_pin_en = 1'h1;
  acc_pkg::acc_aux_stat_t aux_stat;
  logic [3:0] aux_slot;
  logic slot_strobe;
  logic [4:0] bal_channel_now;
  logic [2:0] pin_now;
  logic pin_result_keep;
  logic [15:0] balance_result;
  logic [7:0] current_result_high;
  logic [7:0] current_result_mid;
  logic [7:0] current_result_low;
  logic current_done;
  logic current_running;
  logic first_pin_input_low;
  logic [3:0] last_main = 4'h0;
  int main_div = 0;
  int fails = 0;
  int compares = 0;

  acc_aux_control acc_aux_control_inst (.clk, .srst, .aux_go, .aux_cfg, .sleep_mode, .align_disable,
    .main_cell_target, .main_slot, .main_slot_strobe, .bal_sample, .main_go, .main_stop, .current_decimation_pick,
    .current_sample, .high_byte_read, .cs_ready_pin_en, .aux_stat, .aux_slot, .slot_strobe, .bal_channel_now,
    .pin_now, .pin_result_keep, .balance_result, .current_result_high, .current_result_mid, .current_result_low,
    .current_done, .current_running, .first_pin_input_low);

  // ==========================================
  // clock and main converter slot stream
  always #2 clk = ~clk;
  // slow main slots so the aligned start is easy to see
  always @(negedge clk) begin
    main_div <= (main_div == 11) ? 0 : main_div + 1;
    main_slot_strobe <= (main_div == 11);
    if (main_div == 11) main_slot <= main_slot + 4'h1;
  end
  always @(posedge clk) begin
    if (main_slot_strobe) last_main <= main_slot;
  end

  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic bound_hit(input int i, input int n);
    if (i >= n) begin
      fails++;
      finish_test();
    end
  endtask : bound_hit

  task automatic start(input logic [1:0] mode);
    aux_cfg.run_sel = mode;
    aux_go = 1'h1;
    @(negedge clk);
    aux_go = 1'h0;
  endtask : start

  task automatic first_slot(input logic [3:0] want);
    int i;
    for (i = 0; i < 400 && slot_strobe !== 1'h1; i++) @(negedge clk);
    bound_hit(i, 400);
    check(last_main, want);
    check(aux_slot, acc_pkg::SLOT_DIE);
  endtask : first_slot

  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && aux_stat.running === 1'h1; i++) @(negedge clk);
    bound_hit(i, 3000);
  endtask : wait_idle

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (current_done !== 1'h1 && n < 8000);
    bound_hit(n, 8000);
  endtask : wait_done

  // ==========================================
  // scenarios
  task automatic t_single;
    start(acc_pkg::RUN_SINGLE);
    check(aux_stat.running, 1'h1);
    check({aux_stat.misc_results_ready, aux_stat.balance_results_ready, aux_stat.pin_results_ready}, 3'h0);
    first_slot(4'h7);
    wait_idle();
    check(aux_stat.misc_results_ready, 1'h1);
    check(aux_stat.pin_results_ready, 1'h0);
    check(balance_result, acc_pkg::BAL_DEFAULT);
  endtask : t_single

  task automatic t_cont;
    align_disable = 1'h0;
    aux_cfg.pin_is_input = 8'h0F;
    start(acc_pkg::RUN_CONT);
    first_slot(4'h2);
    // new setting without a start must not stop it
    aux_cfg.run_sel = acc_pkg::RUN_STOP;
    repeat (2500) @(negedge clk);
    check(aux_stat.running, 1'h1);
    check(aux_stat.pin_results_ready, 1'h1);
    start(acc_pkg::RUN_STOP);
    check(aux_stat.running, 1'h0);
  endtask : t_cont

  task automatic t_sleep;
    logic [3:0] hold;
    int i;
    start(acc_pkg::RUN_CONT);
    first_slot(4'h2);
    repeat (4) @(negedge clk);
    sleep_mode = 1'h1;
    @(negedge clk);
    hold = aux_slot;
    repeat (100) @(negedge clk);
    check(aux_slot, hold);
    check(aux_stat.running, 1'h1);
    sleep_mode = 1'h0;
    for (i = 0; i < 300 && aux_slot === hold; i++) @(negedge clk);
    bound_hit(i, 300);
    check(aux_slot !== hold, 1'h1);
    start(acc_pkg::RUN_STOP);
  endtask : t_sleep

  task automatic t_eight;
    int i;
    int rounds;
    int kept;
    logic [7:0] seen;
    logic over;
    rounds = 0;
    kept = 0;
    seen = 8'h00;
    over = 1'h0;
    aux_cfg.highest_active_channel = 4'h4;
    start(acc_pkg::RUN_EIGHT);
    for (i = 0; i < 3000 && aux_stat.running === 1'h1; i++) begin
      if (slot_strobe === 1'h1 && aux_slot === acc_pkg::SLOT_DIE) rounds++;
      if (slot_strobe === 1'h1 && aux_slot === acc_pkg::SLOT_PIN) seen[pin_now] = 1'h1;
      if (slot_strobe === 1'h1 && aux_slot === acc_pkg::SLOT_BAL && bal_channel_now > 5'h04) over = 1'h1;
      if (pin_result_keep === 1'h1) kept++;
      @(negedge clk);
    end
    bound_hit(i, 3000);
    check(rounds, 8);
    check(seen, 8'hFF);
    check(kept, 4);
    check(over, 1'h0);
    check(aux_stat.pin_results_ready, 1'h1);
  endtask : t_eight

  task automatic t_current;
    int p;
    int c1;
    int c2;
    for (p = 0; p < 4; p++) begin
      current_decimation_pick = p[1:0];
      cs_ready_pin_en = 1'(p != 3);
      current_sample = 24'hA55AC3 - 24'(p);
      main_go = 1'h1;
      @(negedge clk);
      main_go = 1'h0;
      wait_done(c1);
      check({current_result_high, current_result_mid, current_result_low}, current_sample);
      check(first_pin_input_low, 1'(p != 3));
      wait_done(c2);
      check(c2, (acc_pkg::CS_CONV_BASE_CYC << p) / 3);
      check(c1 >= 3 * c2, 1'h1);
      high_byte_read = 1'h1;
      @(negedge clk);
      high_byte_read = 1'h0;
      check(first_pin_input_low, 1'h0);
      main_stop = 1'h1;
      @(negedge clk);
      main_stop = 1'h0;
      check(current_running, 1'h0);
    end
  endtask : t_current

  initial begin
    repeat (2) @(negedge clk);
    srst = 1'h0;
    t_single();
    t_cont();
    t_sleep();
    t_eight();
    t_current();
    finish_test();
  end
endmodule : test_aux_and_current_adc_control
